/* File: src/pwr_pkg.sv */
// Package: states, sequencing counts and carrier structs for the power sequencer
package pwr_pkg;
   // Power states of the chip
   typedef enum logic [2:0] {
      ST_OFF,
      ST_RTC_ONLY,
      ST_SLEEP,
      ST_WAKEUP,
      ST_ON
   } pwr_state_t;

   // Number of gated blocks behind the clock control register
   localparam int unsigned NUM_BLOCKS = 8;
   // Recovery memory geometry
   localparam int unsigned REC_DEPTH = 16;
   localparam int unsigned REC_AW = 4;
   localparam int unsigned REC_DW = 32;

   // Settling times in ns, and the derived cycle counts at 100 MHz
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned XTAL_SETTLE_NS = 1000;
   localparam int unsigned PLL_LOCK_NS = 500;
   localparam int unsigned XTAL_SETTLE_CYC = (XTAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 8;

   // Reset values
   localparam logic [NUM_BLOCKS-1:0] CLK_CTRL_RST = 8'h00;

   // Wakeup event sources
   typedef struct packed {
      logic mac;
      logic host;
      logic rtc_timer;
      logic ext_irq;
   } wake_src_t;

   // Power and clock controls driven towards the analog and clock tree
   typedef struct packed {
      logic rtc_pwr_en;
      logic main_pwr_en;
      logic xtal_en;
      logic pll_en;
      logic hs_clk_run;
   } pwr_ctrl_t;
endpackage

/* File: src/rtc_recovery_mem.sv */
// Recovery memory in the always-on RTC domain
`timescale 1ns/1ps
`default_nettype none
module rtc_recovery_mem (
   input wire logic clk,
   input wire logic resetn,
   input wire logic rtc_pwr_en,
   input wire logic wr_en,
   input wire logic [pwr_pkg::REC_AW-1:0] addr,
   input wire logic [pwr_pkg::REC_DW-1:0] wdata,
   output logic [pwr_pkg::REC_DW-1:0] rdata
);
   logic [pwr_pkg::REC_DW-1:0] mem_q [pwr_pkg::REC_DEPTH];
   logic [pwr_pkg::REC_DW-1:0] rdata_q;

   // Contents survive every state that keeps the RTC powered; only off and reset clear them
   always_ff @(posedge clk) begin
      if (!resetn || !rtc_pwr_en) begin
         for (int i = 0; i < pwr_pkg::REC_DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         rdata_q <= '0;
      end else begin
         if (wr_en) begin
            mem_q[addr] <= wdata;
         end
         rdata_q <= mem_q[addr];
      end
   end

   assign rdata = rdata_q;
endmodule
`default_nettype wire

/* File: src/power_state_sequencer.sv */
// Chip power state sequencer: off, rtc-only, sleep, wakeup and on
//
// Notes on behaviour
// - Power-down pin low forces off, clears all.
// - Rtc_only_powered_state powers only the RTC domain.
// - RTC recovery memory retained through rtc_only_powered_state.
// - Sleep keeps RTC running, oscillator disabled.
// - Any wakeup event moves sleep to wakeup.
// - Wakeup enables oscillator and PLLs before on.
// - Sleep states reach on only through wakeup.
// - On state gates clock per control bit.
// - Blocks gate finer; core stops on wait.
`timescale 1ns/1ps
`default_nettype none
module power_state_sequencer (
   input wire logic clk,
   input wire logic resetn,
   input wire logic chip_power_down_pin,
   input wire pwr_pkg::wake_src_t wake_src,
   input wire logic req_sleep,
   input wire logic req_rtc_only,
   input wire logic clk_ctrl_we,
   input wire logic [pwr_pkg::NUM_BLOCKS-1:0] clk_ctrl_wdata,
   input wire logic [pwr_pkg::NUM_BLOCKS-1:0] block_gate_req,
   input wire logic wait_for_interrupt_instr,
   input wire logic core_irq,
   input wire logic rec_wr_en,
   input wire logic [pwr_pkg::REC_AW-1:0] rec_addr,
   input wire logic [pwr_pkg::REC_DW-1:0] rec_wdata,
   output logic [pwr_pkg::REC_DW-1:0] rec_rdata,
   output pwr_pkg::pwr_ctrl_t pwr_ctrl,
   output logic [pwr_pkg::NUM_BLOCKS-1:0] block_clk_en,
   output logic core_clk_en,
   output pwr_pkg::pwr_state_t state
);
   ////////////////////////////////////////////////////////////////////////
   // Pin and event synchronisers
   logic pd_meta_q, pd_sync_q;
   pwr_pkg::wake_src_t wake_meta_q, wake_sync_q;

   // Two flops before any logic looks at the asynchronous inputs
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pd_meta_q <= 1'b0;
         pd_sync_q <= 1'b0;
         wake_meta_q <= '0;
         wake_sync_q <= '0;
      end else begin
         pd_meta_q <= chip_power_down_pin;
         pd_sync_q <= pd_meta_q;
         wake_meta_q <= wake_src;
         wake_sync_q <= wake_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State machine
   pwr_pkg::pwr_state_t state_q, state_d;
   logic [pwr_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic xtal_q, xtal_d;
   logic pll_q, pll_d;

   wire powered_down = !pd_sync_q;
   wire any_wake = |wake_sync_q;
   wire xtal_ready = (cnt_q == pwr_pkg::CNT_W'(pwr_pkg::XTAL_SETTLE_CYC - 1));
   wire pll_ready = (cnt_q == pwr_pkg::CNT_W'(pwr_pkg::PLL_LOCK_CYC - 1));

   // Next state and oscillator bring-up sequencing
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      xtal_d = xtal_q;
      pll_d = pll_q;
      case (state_q)
         pwr_pkg::ST_OFF: begin
            xtal_d = 1'b0;
            pll_d = 1'b0;
            cnt_d = '0;
            if (!powered_down) begin
               state_d = pwr_pkg::ST_WAKEUP;
            end
         end
         pwr_pkg::ST_RTC_ONLY, pwr_pkg::ST_SLEEP: begin
            xtal_d = 1'b0;
            pll_d = 1'b0;
            cnt_d = '0;
            if (any_wake) begin
               state_d = pwr_pkg::ST_WAKEUP;
            end
         end
         pwr_pkg::ST_WAKEUP: begin
            // Oscillator first, PLLs once it settles, then on
            if (!xtal_q) begin
               xtal_d = 1'b1;
               cnt_d = '0;
            end else if (!pll_q) begin
               if (xtal_ready) begin
                  pll_d = 1'b1;
                  cnt_d = '0;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end else if (pll_ready) begin
               state_d = pwr_pkg::ST_ON;
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         pwr_pkg::ST_ON: begin
            // Rtc_only_powered_state takes priority when both are requested
            if (req_rtc_only) begin
               state_d = pwr_pkg::ST_RTC_ONLY;
            end else if (req_sleep) begin
               state_d = pwr_pkg::ST_SLEEP;
            end
            // Oscillator and PLLs drop with the state, else sleep starts one cycle with them on
            if (req_rtc_only || req_sleep) begin
               xtal_d = 1'b0;
               pll_d = 1'b0;
               cnt_d = '0;
            end
         end
         default: begin
            state_d = pwr_pkg::ST_OFF;
         end
      endcase
      if (powered_down) begin
         state_d = pwr_pkg::ST_OFF;
         cnt_d = '0;
         xtal_d = 1'b0;
         pll_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q <= pwr_pkg::ST_OFF;
         cnt_q <= '0;
         xtal_q <= 1'b0;
         pll_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         xtal_q <= xtal_d;
         pll_q <= pll_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock control register, cleared whenever the chip is off
   logic [pwr_pkg::NUM_BLOCKS-1:0] clk_ctrl_q;
   wire main_on = (state_d == pwr_pkg::ST_ON);

   always_ff @(posedge clk) begin
      if (!resetn || powered_down) begin
         clk_ctrl_q <= pwr_pkg::CLK_CTRL_RST;
      end else if (clk_ctrl_we) begin
         clk_ctrl_q <= clk_ctrl_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power and clock outputs, all registered
   pwr_pkg::pwr_ctrl_t ctrl_d, ctrl_q;
   logic [pwr_pkg::NUM_BLOCKS-1:0] blk_en_d, blk_en_q;
   logic core_en_q, core_en_d;

   // Main rail stays up in light sleep; only rtc_only_powered_state and off drop it
   assign ctrl_d.rtc_pwr_en = (state_d != pwr_pkg::ST_OFF);
   assign ctrl_d.main_pwr_en = (state_d == pwr_pkg::ST_SLEEP) || (state_d == pwr_pkg::ST_WAKEUP)
      || main_on;
   assign ctrl_d.xtal_en = xtal_d;
   assign ctrl_d.pll_en = pll_d;
   assign ctrl_d.hs_clk_run = main_on;

   // Per-block gating on top of the control register
   genvar g;
   generate
      for (g = 0; g < pwr_pkg::NUM_BLOCKS; g++) begin : g_blk
         assign blk_en_d[g] = main_on && clk_ctrl_q[g] && !block_gate_req[g];
      end
   endgenerate

   // Core clock parks on wait and resumes on an interrupt or wake event
   always_comb begin
      core_en_d = core_en_q;
      if (!main_on) begin
         core_en_d = 1'b0;
      end else if (core_irq || any_wake) begin
         core_en_d = 1'b1;
      end else if (wait_for_interrupt_instr) begin
         core_en_d = 1'b0;
      end else if (state_q != pwr_pkg::ST_ON) begin
         core_en_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_q <= '0;
         blk_en_q <= '0;
         core_en_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         blk_en_q <= blk_en_d;
         core_en_q <= core_en_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Recovery memory on the always-on rail
   wire rec_we = rec_wr_en && (state_q == pwr_pkg::ST_ON);

   rtc_recovery_mem u_rec (
      .clk(clk),
      .resetn(resetn),
      .rtc_pwr_en(ctrl_q.rtc_pwr_en),
      .wr_en(rec_we),
      .addr(rec_addr),
      .wdata(rec_wdata),
      .rdata(rec_rdata)
   );

   assign pwr_ctrl = ctrl_q;
   assign block_clk_en = blk_en_q;
   assign core_clk_en = core_en_q;
   assign state = state_q;
endmodule
`default_nettype wire

/* File: sim/power_state_sequencer_properties.sv */
// Port checker for the power state sequencer, bound to the design
`timescale 1ns/1ps
`default_nettype none
module power_state_sequencer_properties (
   input wire logic clk,
   input wire logic resetn,
   input wire logic chip_power_down_pin,
   input wire pwr_pkg::wake_src_t wake_src,
   input wire logic [pwr_pkg::NUM_BLOCKS-1:0] block_gate_req,
   input wire logic wait_for_interrupt_instr,
   input wire logic core_irq,
   input wire pwr_pkg::pwr_ctrl_t pwr_ctrl,
   input wire logic [pwr_pkg::NUM_BLOCKS-1:0] block_clk_en,
   input wire logic core_clk_en,
   input wire pwr_pkg::pwr_state_t state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////
   // Steps of a wakeup, shared by the sequencing checks
   sequence s_wake_entry;
      state != pwr_pkg::ST_WAKEUP ##1 state == pwr_pkg::ST_WAKEUP;
   endsequence
   sequence s_woken;
      (state inside {pwr_pkg::ST_SLEEP, pwr_pkg::ST_RTC_ONLY} && wake_src != '0 && chip_power_down_pin)[*3];
   endsequence
   ////////////////////////////////////////////////////////////////
   // Four low samples cover the two sync flops and the state edge
   property p_off; !chip_power_down_pin [*4] |=> state == pwr_pkg::ST_OFF && pwr_ctrl == '0; endproperty
   a_off: assert property (p_off) else $error("pin low but not off");
   property p_deep; state == pwr_pkg::ST_RTC_ONLY |-> pwr_ctrl == 5'h10; endproperty
   a_deep: assert property (p_deep) else $error("rtc_only_powered_state power wrong");
   property p_sleep; state == pwr_pkg::ST_SLEEP |-> pwr_ctrl.rtc_pwr_en && !pwr_ctrl.xtal_en; endproperty
   a_sleep: assert property (p_sleep) else $error("oscillator on in sleep");
   property p_wake; s_woken |=> state == pwr_pkg::ST_WAKEUP; endproperty
   a_wake: assert property (p_wake) else $error("wake event ignored");
   // Oscillator first, then a long settle before the on state
   property p_wake_time; s_wake_entry |-> ##[1:2] pwr_ctrl.xtal_en ##[99:200] state == pwr_pkg::ST_ON; endproperty
   a_wake_time: assert property (p_wake_time) else $error("wakeup sequence wrong");
   property p_path; $changed(state) && state == pwr_pkg::ST_ON |-> $past(state) == pwr_pkg::ST_WAKEUP; endproperty
   a_path: assert property (p_path) else $error("on entered not via wakeup");
   property p_gate_off; state != pwr_pkg::ST_ON |-> block_clk_en == '0 && pwr_ctrl.hs_clk_run == 1'b0; endproperty
   a_gate_off: assert property (p_gate_off) else $error("block clock outside on");
   property p_fine; state == pwr_pkg::ST_ON |=> (block_clk_en & $past(block_gate_req)) == '0; endproperty
   a_fine: assert property (p_fine) else $error("gated block still clocked");
   // A wake event seen two samples back still restarts the core, so it is excluded
   property p_wfi; $stable(state) && state == pwr_pkg::ST_ON && wait_for_interrupt_instr && !core_irq
      && $past(wake_src, 2) == '0 |=> !core_clk_en;
   endproperty
   a_wfi: assert property (p_wfi) else $error("core clock kept in wait");
endmodule
bind power_state_sequencer power_state_sequencer_properties u_props (.clk(clk), .resetn(resetn),
   .chip_power_down_pin(chip_power_down_pin), .wake_src(wake_src), .block_gate_req(block_gate_req),
   .wait_for_interrupt_instr(wait_for_interrupt_instr), .core_irq(core_irq), .pwr_ctrl(pwr_ctrl),
   .block_clk_en(block_clk_en), .core_clk_en(core_clk_en), .state(state));
`default_nettype wire

/* File: sim/pwr_partner.sv */
// Model of the power-down pin driver and the wake event sources
`timescale 1ns/1ps
`default_nettype none
module pwr_partner (
   input wire logic clk,
   input wire logic off_req,
   input wire logic [1:0] wake_sel,
   input wire logic wake_go,
   output logic chip_power_down_pin,
   output pwr_pkg::wake_src_t wake_src
);
   logic [2:0] hold_q = 3'h0;
   initial chip_power_down_pin = 1'b0;
   initial wake_src = '0;
   // Wake held four cycles, since the sequencer syncs it through two flops
   always @(posedge clk) begin
      chip_power_down_pin <= !off_req;
      if (wake_go) begin
         hold_q <= 3'h4;
         wake_src <= 4'h8 >> wake_sel;
      end else if (hold_q != 3'h0) begin
         hold_q <= hold_q - 3'h1;
         if (hold_q == 3'h1) wake_src <= '0;
      end
   end
endmodule
`default_nettype wire

/* File: sim/power_state_sequencer_tb.sv */
// Self-checking bench for the power state sequencer
`timescale 1ns/1ps
`default_nettype none
module power_state_sequencer_tb;
   logic clk = 1'b0, resetn = 1'b0, off_req = 1'b1, wake_go = 1'b0, req_sleep = 1'b0, req_rtc_only = 1'b0;
   logic clk_ctrl_we = 1'b0, wfi = 1'b0, core_irq = 1'b0, rec_wr_en = 1'b0, chip_power_down_pin, core_clk_en;
   logic [1:0] wake_sel = 2'h0;
   logic [7:0] wdata = 8'h00, gate = 8'h00, block_clk_en;
   logic [3:0] rec_addr = 4'h0;
   logic [31:0] rec_wdata = 32'h0, rec_rdata, mem_exp [16];
   pwr_pkg::wake_src_t wake_src;
   pwr_pkg::pwr_ctrl_t pwr_ctrl;
   pwr_pkg::pwr_state_t state;
   int n_fail = 0, checked = 0, cyc = 0, seed;
   always #5 clk = ~clk;
   pwr_partner far (.clk(clk), .off_req(off_req), .wake_sel(wake_sel), .wake_go(wake_go),
      .chip_power_down_pin(chip_power_down_pin), .wake_src(wake_src));
   power_state_sequencer dut (.clk(clk), .resetn(resetn), .chip_power_down_pin(chip_power_down_pin),
      .wake_src(wake_src), .req_sleep(req_sleep), .req_rtc_only(req_rtc_only), .clk_ctrl_we(clk_ctrl_we),
      .clk_ctrl_wdata(wdata), .block_gate_req(gate), .wait_for_interrupt_instr(wfi), .core_irq(core_irq),
      .rec_wr_en(rec_wr_en), .rec_addr(rec_addr), .rec_wdata(rec_wdata), .rec_rdata(rec_rdata),
      .pwr_ctrl(pwr_ctrl), .block_clk_en(block_clk_en), .core_clk_en(core_clk_en), .state(state));
   ////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait for a state, sampled on the falling edge
   task automatic wait_st(input pwr_pkg::pwr_state_t s);
      for (int i = 0; i < 400 && state !== s; i++) @(negedge clk);
      chk_val(32'(state), 32'(s));
   endtask
   task automatic to_on();
      wait_st(pwr_pkg::ST_WAKEUP);
      repeat (3) @(negedge clk);
      chk_val(pwr_ctrl, 5'h1c);
      wait_st(pwr_pkg::ST_ON);
      chk_val(pwr_ctrl, 5'h1f);
   endtask
   // Blocks run only when enabled and not finely gated
   function automatic logic [7:0] exp_blk(input logic [7:0] w, input logic [7:0] g);
      return w & ~g;
   endfunction
   // Cycle ceiling against a hung sequence
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      seed = $urandom(62);
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      chk_val(pwr_ctrl, 5'h00);
      @(posedge clk) off_req <= 1'b0;
      to_on();
      for (int i = 0; i < 6; i++) begin
         @(posedge clk) begin
            clk_ctrl_we <= 1'b1;
            wdata <= i == 0 ? 8'hff : 8'($urandom);
            gate <= i == 0 ? 8'h00 : 8'($urandom);
         end
         @(posedge clk) clk_ctrl_we <= 1'b0;
         repeat (3) @(negedge clk);
         chk_val(block_clk_en, exp_blk(wdata, gate));
      end
      @(posedge clk) wfi <= 1'b1;
      repeat (3) @(negedge clk);
      chk_val(core_clk_en, 1'b0);
      @(posedge clk) begin
         wfi <= 1'b0;
         core_irq <= 1'b1;
      end
      @(posedge clk) core_irq <= 1'b0;
      repeat (2) @(negedge clk);
      chk_val(core_clk_en, 1'b1);
      foreach (mem_exp[a]) begin
         mem_exp[a] = $urandom;
         @(posedge clk) begin
            rec_wr_en <= 1'b1;
            rec_addr <= 4'(a);
            rec_wdata <= mem_exp[a];
         end
      end
      @(posedge clk) rec_wr_en <= 1'b0;
      // Every wake source from both sleep depths
      for (int s = 0; s < 8; s++) begin
         @(posedge clk) begin
            req_sleep <= s[2];
            req_rtc_only <= !s[2];
         end
         wait_st(s[2] ? pwr_pkg::ST_SLEEP : pwr_pkg::ST_RTC_ONLY);
         // Recovery writes outside on must be refused; readback of word 0 shows it
         @(posedge clk) begin
            req_sleep <= 1'b0;
            req_rtc_only <= 1'b0;
            rec_wr_en <= (s[1:0] == 2'h0);
            rec_addr <= 4'h0;
            rec_wdata <= ~mem_exp[0];
         end
         repeat (20) @(negedge clk);
         chk_val(pwr_ctrl, s[2] ? 5'h18 : 5'h10);
         @(posedge clk) begin
            wake_sel <= 2'(s);
            wake_go <= 1'b1;
            rec_wr_en <= 1'b0;
         end
         @(posedge clk) wake_go <= 1'b0;
         to_on();
      end
      foreach (mem_exp[a]) begin
         @(posedge clk) rec_addr <= 4'(a);
         repeat (2) @(negedge clk);
         chk_val(rec_rdata, mem_exp[a]);
      end
      @(posedge clk) off_req <= 1'b1;
      repeat (6) @(negedge clk);
      chk_val(32'(state), 32'(pwr_pkg::ST_OFF));
      chk_val(pwr_ctrl, 5'h00);
      end_of_test();
   end
endmodule
`default_nettype wire
